/* File: src/mcr_field.sv */
`timescale 1ns/100ps
// ********************************************************************
// constants shared by the control-register logic
// ********************************************************************
package mcr_pkg;
   localparam logic [4:0] ADDR_HI      = 5'h10;   // upper five address bits
   localparam logic [3:0] BYTE_BITS    = 4'h8;
   // command codes in bits 7:5 of a command byte
   localparam logic [2:0] CMD_IN_ATT   = 3'h0;
   localparam logic [2:0] CMD_BASS     = 3'h1;
   localparam logic [2:0] CMD_TREBLE   = 3'h2;
   localparam logic [2:0] CMD_RVOL     = 3'h3;
   localparam logic [2:0] CMD_LVOL     = 3'h4;
   localparam logic [2:0] CMD_MIC_SG   = 3'h5;
   localparam logic [2:0] CMD_MIC_VOL  = 3'h6;
   localparam logic [2:0] CMD_GEN      = 3'h7;
   // field widths and positions
   localparam int         ATT_W        = 3;
   localparam int         TONE_W       = 4;
   localparam int         VOL_W        = 5;
   localparam int         SG_W         = 4;
   localparam int         GEN_W        = 5;
   localparam int         SG_SEL_LSB   = 0;
   localparam int         SG_GAIN_LSB  = 2;
   localparam int         GEN_ENH_BIT  = 2;
   localparam int         GEN_MONO_BIT = 3;
   // field codes
   localparam logic [1:0] GAIN_BAD     = 2'h3;
   localparam logic [4:0] MIC_VOL_MAX  = 5'h15;   // 21 = mute, above is undefined
   // reset values
   localparam logic [2:0] RST_IN_ATT   = 3'h0;
   localparam logic [3:0] RST_TONE     = 4'h6;    // flat
   localparam logic [4:0] RST_PA_VOL   = 5'h1f;   // power amp muted
   localparam logic [3:0] RST_MIC_SG   = 4'h8;    // input 1, +30 dB
   localparam logic [4:0] RST_MIC_VOL  = 5'h15;   // microphone muted
   localparam logic [4:0] RST_GEN      = 5'h00;
endpackage

// ********************************************************************
// one control register with its power-up value
// ********************************************************************
module mcr_field #(
   parameter int           W   = 4,
   parameter logic [W-1:0] RST = '0
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_i,
   input  wire logic         we_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] val;
   } mcr_field_t;

   mcr_field_t s_reg;
   mcr_field_t s_next;

   always_comb begin
      s_next = s_reg;
      if (we_i) begin
         s_next.val = d_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg.val <= RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign q_o = s_reg.val;
endmodule // mcr_field

/* File: src/mcr_regs.sv */
`timescale 1ns/100ps
module mcr_regs
(
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_i,
   input  wire logic                        scl_i,
   input  wire logic                        sda_i,
   output logic                             sda_o,
   output logic                             sda_oe_n_o,
   input  wire logic                        addr1_i,
   input  wire logic                        addr2_i,
   output logic [mcr_pkg::SG_W-1:0]         mic_sel_gain_o,
   output logic [mcr_pkg::VOL_W-1:0]        mic_vol_o,
   output logic [mcr_pkg::VOL_W-1:0]        left_vol_o,
   output logic [mcr_pkg::VOL_W-1:0]        right_vol_o,
   output logic [mcr_pkg::TONE_W-1:0]       bass_o,
   output logic [mcr_pkg::TONE_W-1:0]       treble_o,
   output logic [mcr_pkg::ATT_W-1:0]        in_att_o,
   output logic [mcr_pkg::GEN_W-1:0]        gen_ctrl_o
);
   import mcr_pkg::*;

   // ****************************************************************
   // serial bus receiver state
   // ****************************************************************
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_ADDR  = 5'h02,
      ST_ACK_A = 5'h04,
      ST_DATA  = 5'h08,
      ST_ACK_D = 5'h10
   } mcr_state_t;

   typedef struct packed {
      mcr_state_t st;
      logic [7:0] shft;
      logic [3:0] cnt;
      logic       scl_q;
      logic       sda_q;
      logic       drv;
   } mcr_regs_t;

   mcr_regs_t  s_reg;
   mcr_regs_t  s_next;
   logic       wr;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   logic [6:0] dev_addr;
   logic [2:0] cmd;
   logic       we_att;
   logic       we_bass;
   logic       we_treb;
   logic       we_rvol;
   logic       we_lvol;
   logic       we_sg;
   logic       we_mvol;
   logic       we_gen;

   assign dev_addr = {ADDR_HI, addr2_i, addr1_i};
   assign rise     = ~s_reg.scl_q & scl_i;
   assign fall     = s_reg.scl_q & ~scl_i;
   assign start    = s_reg.scl_q & scl_i & s_reg.sda_q & ~sda_i;
   assign stop     = s_reg.scl_q & scl_i & ~s_reg.sda_q & sda_i;

   always_comb begin
      s_next       = s_reg;
      wr           = 1'b0;
      s_next.scl_q = scl_i;
      s_next.sda_q = sda_i;
      if (start) begin
         s_next.st  = ST_ADDR;
         s_next.cnt = 4'h0;
         s_next.drv = 1'b0;
      end else if (stop) begin
         s_next.st  = ST_IDLE;
         s_next.drv = 1'b0;
      end else begin
         case (s_reg.st)
            ST_ADDR, ST_DATA: begin
               if (rise && s_reg.cnt < BYTE_BITS) begin
                  s_next.shft = {s_reg.shft[6:0], sda_i};
                  s_next.cnt  = s_reg.cnt + 4'h1;
               end else if (fall && s_reg.cnt == BYTE_BITS) begin
                  if (s_reg.st == ST_DATA) begin
                     s_next.st  = ST_ACK_D;
                     s_next.drv = 1'b1;
                     wr         = 1'b1;
                  end else if (s_reg.shft[7:1] == dev_addr && !s_reg.shft[0]) begin
                     s_next.st  = ST_ACK_A;
                     s_next.drv = 1'b1;
                  end else begin
                     s_next.st  = ST_IDLE;
                  end
               end
            end
            ST_ACK_A, ST_ACK_D: begin
               if (fall) begin
                  s_next.st  = ST_DATA;
                  s_next.cnt = 4'h0;
                  s_next.drv = 1'b0;
               end
            end
            ST_IDLE: begin
               s_next.drv = 1'b0;
            end
            default: begin
               s_next.st  = ST_IDLE;
               s_next.drv = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg.st    <= ST_IDLE;
         s_reg.shft  <= 8'h00;
         s_reg.cnt   <= 4'h0;
         s_reg.scl_q <= 1'b1;
         s_reg.sda_q <= 1'b1;
         s_reg.drv   <= 1'b0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign sda_o      = 1'b0;
   assign sda_oe_n_o = ~s_reg.drv;

   // ****************************************************************
   // command decode and control registers
   // ****************************************************************
   assign cmd     = s_reg.shft[7:5];
   assign we_att  = wr && cmd == CMD_IN_ATT;
   assign we_bass = wr && cmd == CMD_BASS;
   assign we_treb = wr && cmd == CMD_TREBLE;
   assign we_rvol = wr && cmd == CMD_RVOL;
   assign we_lvol = wr && cmd == CMD_LVOL;
   assign we_sg   = wr && cmd == CMD_MIC_SG && s_reg.shft[3:2] != GAIN_BAD;
   assign we_mvol = wr && cmd == CMD_MIC_VOL && s_reg.shft[4:0] <= MIC_VOL_MAX;

   // reset values of every field come from the package
   mcr_field #(.W(ATT_W), .RST(RST_IN_ATT)) u_att (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_att),
      .d_i (s_reg.shft[ATT_W-1:0]), .q_o (in_att_o));
   mcr_field #(.W(TONE_W), .RST(RST_TONE)) u_bass (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_bass),
      .d_i (s_reg.shft[TONE_W-1:0]), .q_o (bass_o));
   mcr_field #(.W(TONE_W), .RST(RST_TONE)) u_treb (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_treb),
      .d_i (s_reg.shft[TONE_W-1:0]), .q_o (treble_o));
   mcr_field #(.W(VOL_W), .RST(RST_PA_VOL)) u_rvol (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_rvol),
      .d_i (s_reg.shft[VOL_W-1:0]), .q_o (right_vol_o));
   mcr_field #(.W(VOL_W), .RST(RST_PA_VOL)) u_lvol (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_lvol),
      .d_i (s_reg.shft[VOL_W-1:0]), .q_o (left_vol_o));
   mcr_field #(.W(SG_W), .RST(RST_MIC_SG)) u_sg (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_sg),
      .d_i (s_reg.shft[SG_W-1:0]), .q_o (mic_sel_gain_o));
   mcr_field #(.W(VOL_W), .RST(RST_MIC_VOL)) u_mvol (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_mvol),
      .d_i (s_reg.shft[VOL_W-1:0]), .q_o (mic_vol_o));
   mcr_field #(.W(GEN_W), .RST(RST_GEN)) u_gen (
      .sys_clk_i (sys_clk_i), .rst_i (rst_i), .we_i (we_gen),
      .d_i (s_reg.shft[GEN_W-1:0]), .q_o (gen_ctrl_o));
   assign we_gen = wr && cmd == CMD_GEN;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   reset_defaults_a: assert property ($past(rst_i) |->
      in_att_o == RST_IN_ATT && gen_ctrl_o == RST_GEN)
      else $error("control registers not at defaults after reset");
   mic_sg_write_a: assert property (we_sg |=>
      mic_sel_gain_o == $past(s_reg.shft[SG_W-1:0]))
      else $error("mic select and gain not written");
   mic_vol_write_a: assert property (we_mvol |=>
      mic_vol_o == $past(s_reg.shft[VOL_W-1:0]))
      else $error("mic volume not written");
   mute_reset_a: assert property ($past(rst_i) |->
      left_vol_o == RST_PA_VOL && right_vol_o == RST_PA_VOL && mic_vol_o == RST_MIC_VOL)
      else $error("outputs not muted after reset");
   mic_sg_reset_a: assert property ($past(rst_i) |-> mic_sel_gain_o == RST_MIC_SG)
      else $error("mic select and gain default wrong");
   tone_reset_a: assert property ($past(rst_i) |-> bass_o == RST_TONE &&
      treble_o == RST_TONE && !gen_ctrl_o[GEN_ENH_BIT] && !gen_ctrl_o[GEN_MONO_BIT])
      else $error("tone or mode default wrong");
   bad_gain_keep_a: assert property (wr && cmd == CMD_MIC_SG &&
      s_reg.shft[3:2] == GAIN_BAD |=> $stable(mic_sel_gain_o))
      else $error("undefined gain code changed register");
   mic_vol_range_a: assert property (mic_vol_o <= MIC_VOL_MAX)
      else $error("mic volume holds undefined code");
   addr_match_a: assert property (s_reg.st == ST_ACK_A |->
      s_reg.shft[7:1] == dev_addr && !s_reg.shft[0])
      else $error("acknowledged a foreign address");
   ack_hold_a: assert property (s_reg.drv && scl_i |=> s_reg.drv)
      else $error("acknowledge released while clock high");
   multi_byte_a: assert property (s_reg.st == ST_ACK_D && fall && !start && !stop |=>
      s_reg.st == ST_DATA && s_reg.cnt == 4'h0)
      else $error("no return to data after byte acknowledge");
endmodule // mcr_regs

/* File: tb/mcr_master.sv */
`timescale 1ns/100ps
// ********************************************************************
// two-wire bus master model, open drain, releases data high
// ********************************************************************
module mcr_master (
   input  wire logic sys_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic drv(input logic c, input logic d, input int n);
      scl_o <= c;
      sda_o <= d;
      repeat (n) @(posedge sys_clk_i);
   endtask
   task automatic start();
      drv(1'b1, 1'b1, 3);
      drv(1'b1, 1'b0, 3);
   endtask
   task automatic stop();
      drv(1'b0, sda_o, 1);
      drv(1'b0, 1'b0, 2);
      drv(1'b1, 1'b0, 3);
      drv(1'b1, 1'b1, 3);
   endtask
   // data changes only while the clock is low
   task automatic byte_out(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         drv(1'b0, sda_o, 1);
         drv(1'b0, b[i], 2);
         drv(1'b1, b[i], 3);
      end
      drv(1'b0, sda_o, 1);
      drv(1'b0, 1'b1, 2);
      scl_o <= 1'b1;
      ack = 1'b1;
      repeat (3) begin
         @(posedge sys_clk_i);
         ack = ack & (sda_i === 1'b0);
      end
   endtask
endmodule // mcr_master

/* File: tb/mic_control_registers_tb.sv */
`timescale 1ns/100ps
// ********************************************************************
// register bank bench
// ********************************************************************
module mic_control_registers_tb;
   import mcr_pkg::*;
   logic       sys_clk, rst, scl, m_sda, sda_o, sda_oe_n, a1, a2, ack;
   wire logic  sda_w;
   logic [3:0] sg, bs, tr;
   logic [4:0] mv, lv, rv, gen;
   logic [2:0] att;
   int         err_count, n_checks;
   int         codes[6] = '{0, 1, 21, 20, 22, 31};
   assign sda_w = m_sda & (sda_oe_n | sda_o);
   mcr_regs dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w),
      .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr1_i(a1), .addr2_i(a2),
      .mic_sel_gain_o(sg), .mic_vol_o(mv), .left_vol_o(lv), .right_vol_o(rv),
      .bass_o(bs), .treble_o(tr), .in_att_o(att), .gen_ctrl_o(gen));
   mcr_master master_u (.sys_clk_i(sys_clk), .sda_i(sda_w), .scl_o(scl), .sda_o(m_sda));
   always #5 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", err_count, n_checks);
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic defaults();
      chk({4'h0, sg}, 8'h08);
      chk({3'h0, mv}, 8'h15);
      chk({3'h0, lv}, 8'h1f);
      chk({3'h0, rv}, 8'h1f);
      chk({bs, tr}, 8'h66);
      chk({3'h0, gen}, 8'h00);
      chk({5'h00, att}, 8'h00);
      chk({7'h00, sda_oe_n}, 8'h01);
   endtask
   task automatic put(input logic [7:0] d);
      master_u.byte_out(d, ack);
      chk({7'h00, ack}, 8'h01);
   endtask
   task automatic addr(input logic [7:0] ab, input logic exp);
      master_u.start();
      master_u.byte_out(ab, ack);
      chk({7'h00, ack}, {7'h00, exp});
   endtask
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      a1 = 1'b0;
      a2 = 1'b1;
      err_count = 0;
      n_checks = 0;
      repeat (6) @(posedge sys_clk);
      defaults();
      rst <= 1'b0;
      @(posedge sys_clk);
      addr(8'h84, 1'b1);
      for (int i = 0; i < 12; i++) begin
         put(8'ha0 + 8'(i));
         chk({4'h0, sg}, {4'h0, 4'(i)});
      end
      put(8'had);
      chk({4'h0, sg}, 8'h0b);
      foreach (codes[k]) begin
         put({3'h6, 5'(codes[k])});
         chk({3'h0, mv}, (codes[k] <= 21) ? 8'(codes[k]) : 8'h14);
      end
      master_u.stop();
      addr(8'h80, 1'b0);
      master_u.byte_out(8'hc1, ack);
      master_u.stop();
      addr(8'h85, 1'b0);
      master_u.byte_out(8'hc1, ack);
      master_u.stop();
      chk({3'h0, mv}, 8'h14);
      a1 <= 1'b1;
      a2 <= 1'b0;
      addr(8'h82, 1'b1);
      put(8'hc0);
      chk({3'h0, mv}, 8'h00);
      put(8'h2a);
      put(8'h45);
      put(8'h6e);
      put(8'h83);
      put(8'h05);
      put(8'he4);
      chk({bs, tr}, 8'ha5);
      chk({3'h0, rv}, 8'h0e);
      chk({3'h0, lv}, 8'h03);
      chk({5'h00, att}, 8'h05);
      chk({3'h0, gen}, 8'h04);
      master_u.stop();
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      defaults();
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      addr(8'h82, 1'b1);
      put(8'ha9);
      chk({4'h0, sg}, 8'h09);
      master_u.stop();
      wrap_up();
   end
   initial begin
      #200000;
      err_count++;
      wrap_up();
   end
endmodule // mic_control_registers_tb
